// file: hdl/standby_wake_reset_control.sv
// Reset, power-fail and wake-up timer standby sequencer with an APB register slave.
//
// Function
// - Standby is left only by hardware reset, a first or second wake timer overflow, or an external interrupt.
// - A reset wake returns every control register to its initial value.
// - An interrupt or timer wake keeps RAM and all control registers unchanged.
// - A non-reset wake with the global interrupt enable set requests the normal interrupt response.
// - A non-reset wake with the global interrupt enable clear resumes after the halt opcode without vectoring.
// - An interrupt or timer wake resumes with no oscillator stabilisation delay.
// - After reset release, execution starts after 64 ms plus 7 further oscillator periods.
// - No reset clears internal RAM.
// - Power-fail detection is enabled while its disable bit is clear and off while it is set.
// - A low supply lasting over 50 ns resets the device only when the reset select bit asks for it.
// - The power-fail threshold comes from a configuration word level bit, not from a register.
// - Standby is entered by the halt opcode after the standby-select bit of the clock control register is set.
// - In standby only the prescaler at its 2048 ratio and the two wake timers run.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "standby_wake_map.svh"
module standby_wake_reset_control
    import standby_wake_pkg::*;
#(
    parameter int STARTUP_CYCLES = `STARTUP_DELAY_MS * (`MCLK_HZ / 1000) + `STARTUP_EXTRA_PERIODS,
    parameter int CNT_WIDTH = 24
) (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic RESET_PIN_B,
    input wire logic SUPPLY_LOW,
    input wire logic POWER_FAIL_LEVEL_SELECT,
    input wire logic HALT_EXEC,
    input wire logic FIRST_WAKE_TIMER_OVF,
    input wire logic SECOND_WAKE_TIMER_OVF,
    input wire logic EXT_IRQ,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic CORE_RESET_B,
    output logic CORE_RUN,
    output logic CORE_RESUME,
    output logic CORE_VECTOR,
    output logic [2:0] CORE_WAKE_SRC,
    output logic PRESCALE_TICK,
    output logic WAKE_TIMER_RUN,
    output logic STANDBY_ACTIVE,
    output logic POWER_FAIL_LEVEL
);
    localparam int PFAIL_CYCLES_RAW = (`PFAIL_GLITCH_NS * (`MCLK_HZ / 1000000)) / 1000;
    localparam int PFAIL_CYCLES = PFAIL_CYCLES_RAW < 1 ? 1 : PFAIL_CYCLES_RAW;
    localparam int RESET_LOW_CYCLES = `RESET_LOW_PERIODS;

    typedef struct packed {
        seq_state_t state;
        logic [CNT_WIDTH-1:0] cnt;
        logic [10:0] prescale;
        logic [7:0] clock_control;
        logic [7:0] power_fail_config;
        logic global_irq_enable;
        logic reset_req;
        logic core_reset_b;
        logic core_run;
        logic core_resume;
        logic core_vector;
        wake_src_t wake_src;
        wake_src_t wake_latched;
        logic prescale_tick;
        logic standby;
        logic pf_level;
        logic timer_run;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ctrl_t;

    ctrl_t r;
    ctrl_t next_r;
    logic pin_reset_hit;
    logic supply_low_hit;
    logic pfail_meta;
    logic pfail_sync;
    logic supply_meta;
    logic supply_sync;
    logic [1:0] wake_meta;
    logic [1:0] wake_sync;
    logic ext_meta;
    logic ext_sync;
    wake_src_t wake_now;
    logic pf_enabled;
    logic apb_access;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and low-period filters.

    sync_count_filter #(
        .WIDTH(CNT_WIDTH),
        .LIMIT(CNT_WIDTH'(RESET_LOW_CYCLES - 1))
    ) u_pin_filter (
        .clk(MCLK),
        .rst_b(RST_B),
        .din_b(RESET_PIN_B),
        .hit(pin_reset_hit)
    );

    // glitch filter on supply
    // The monitor flag is synchronised before the enable gate so no logic sees the raw pin.
    sync_count_filter #(
        .WIDTH(CNT_WIDTH),
        .LIMIT(CNT_WIDTH'(PFAIL_CYCLES))
    ) u_supply_filter (
        .clk(MCLK),
        .rst_b(RST_B),
        .din_b(!(supply_sync && pf_enabled)),
        .hit(supply_low_hit)
    );

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            wake_meta <= 2'h0;
            wake_sync <= 2'h0;
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            pfail_meta <= 1'b0;
            pfail_sync <= 1'b0;
            supply_meta <= 1'b0;
            supply_sync <= 1'b0;
        end else begin
            wake_meta <= {FIRST_WAKE_TIMER_OVF, SECOND_WAKE_TIMER_OVF};
            wake_sync <= wake_meta;
            ext_meta <= EXT_IRQ;
            ext_sync <= ext_meta;
            pfail_meta <= POWER_FAIL_LEVEL_SELECT;
            pfail_sync <= pfail_meta;
            supply_meta <= SUPPLY_LOW;
            supply_sync <= supply_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer and register file.

    assign pf_enabled = !r.power_fail_config[`POWER_FAIL_DISABLE_BIT];
    assign apb_access = PSEL && PENABLE && !r.pready;

    always_comb begin
        wake_now = '{first_wake_timer: wake_sync[1], second_wake_timer: wake_sync[0], ext_irq: ext_sync};
        next_r = r;
        next_r.core_resume = 1'b0;
        next_r.core_vector = 1'b0;
        next_r.prescale_tick = 1'b0;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        next_r.pf_level = pfail_sync;
        next_r.reset_req = pin_reset_hit ||
            (supply_low_hit && r.power_fail_config[`POWER_FAIL_RESET_SELECT_BIT]);
        next_r.prescale = r.prescale + 11'h001;
        if (r.prescale == 11'(`PRESCALE_RATIO - 1)) begin
            next_r.prescale_tick = 1'b1;
        end
        if (apb_access) begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0;
            unique case (PADDR)
                `CLOCK_CONTROL_REG_OFFSET: begin
                    if (PWRITE) begin
                        next_r.clock_control = PWDATA[7:0];
                    end
                    next_r.prdata = {24'h0, r.clock_control};
                end
                `POWER_FAIL_CONFIG_REG_OFFSET: begin
                    if (PWRITE) begin
                        next_r.power_fail_config = PWDATA[7:0];
                    end
                    next_r.prdata = {24'h0, r.power_fail_config};
                end
                `WAKE_CONTROL_OFFSET: begin
                    if (PWRITE) begin
                        next_r.global_irq_enable = PWDATA[`GLOBAL_IRQ_ENABLE_BIT];
                    end
                    next_r.prdata = {30'h0, r.global_irq_enable, 1'b0};
                end
                `WAKE_STATUS_OFFSET: begin
                    next_r.prdata = {24'h0, 3'h0, r.state};
                    next_r.prdata[10:8] = r.wake_latched;
                end
                default: begin
                    next_r.pslverr = 1'b1;
                end
            endcase
        end
        unique case (r.state)
            ST_RESET: begin
                next_r.cnt = '0;
                next_r.state = ST_START;
            end
            ST_START: begin
                next_r.cnt = r.cnt + 1'b1;
                if (r.cnt == CNT_WIDTH'(STARTUP_CYCLES - 1)) begin
                    next_r.core_reset_b = 1'b1;
                    next_r.core_run = 1'b1;
                    next_r.state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (HALT_EXEC && r.clock_control[`TIMER_STANDBY_SELECT_BIT]) begin
                    next_r.core_run = 1'b0;
                    next_r.standby = 1'b1;
                    next_r.state = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (wake_now != 3'h0) begin
                    next_r.wake_src = wake_now;
                    next_r.wake_latched = wake_now;
                    next_r.state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                next_r.standby = 1'b0;
                next_r.core_run = 1'b1;
                if (r.global_irq_enable) begin
                    next_r.core_vector = 1'b1;
                end else begin
                    next_r.core_resume = 1'b1;
                end
                next_r.state = ST_RUN;
            end
        endcase
        if (r.reset_req) begin
            // no RAM clear is driven here
            next_r.state = ST_RESET;
            next_r.clock_control = `CLOCK_CONTROL_RESET;
            next_r.power_fail_config = `POWER_FAIL_CONFIG_RESET;
            next_r.global_irq_enable = 1'b0;
            next_r.core_reset_b = 1'b0;
            next_r.core_run = 1'b0;
            next_r.standby = 1'b0;
            next_r.wake_src = '0;
            next_r.wake_latched = '0;
            next_r.core_resume = 1'b0;
            next_r.core_vector = 1'b0;
        end
        // The wake timers run in both run and standby; kept in a flop so the output is registered.
        next_r.timer_run = next_r.core_run || next_r.standby;
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            r <= '{state: ST_RESET, cnt: '0, prescale: 11'h000, clock_control: `CLOCK_CONTROL_RESET,
                power_fail_config: `POWER_FAIL_CONFIG_RESET, global_irq_enable: 1'b0, reset_req: 1'b0,
                core_reset_b: 1'b0, core_run: 1'b0, core_resume: 1'b0, core_vector: 1'b0,
                wake_src: 3'h0, wake_latched: 3'h0, prescale_tick: 1'b0, standby: 1'b0, pf_level: 1'b0,
                timer_run: 1'b0, prdata: 32'h0, pready: 1'b0, pslverr: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register.

    assign PRDATA = r.prdata;
    assign PREADY = r.pready;
    assign PSLVERR = r.pslverr;
    assign CORE_RESET_B = r.core_reset_b;
    assign CORE_RUN = r.core_run;
    assign CORE_RESUME = r.core_resume;
    assign CORE_VECTOR = r.core_vector;
    assign CORE_WAKE_SRC = r.wake_src;
    assign PRESCALE_TICK = r.prescale_tick;
    assign WAKE_TIMER_RUN = r.timer_run;
    assign STANDBY_ACTIVE = r.standby;
    assign POWER_FAIL_LEVEL = r.pf_level;
endmodule

// file: hdl/sync_count_filter.sv
// Two-flop synchroniser followed by a low-level run counter that asserts once the run reaches a threshold.
`timescale 1ns/1ps
module sync_count_filter
    import standby_wake_pkg::*;
#(
    parameter int WIDTH = 24,
    parameter logic [WIDTH-1:0] LIMIT = WIDTH'(8)
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic din_b,
    output logic hit
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic [WIDTH-1:0] run;
        logic hit;
    } filt_t;

    filt_t r;
    filt_t next_r;

    always_comb begin
        next_r = r;
        next_r.meta = din_b;
        next_r.sync = r.meta;
        if (r.sync) begin
            next_r.run = '0;
        end else if (r.run != LIMIT) begin
            next_r.run = r.run + 1'b1;
        end
        next_r.hit = !r.sync && (r.run == LIMIT);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '{meta: 1'b1, sync: 1'b1, run: '0, hit: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign hit = r.hit;
endmodule

// file: shared/standby_wake_map.svh
// Register offsets, field positions, reset values and timing counts of the standby, wake and reset sequencer.
`ifndef STANDBY_WAKE_MAP_SVH
`define STANDBY_WAKE_MAP_SVH

`define CLOCK_CONTROL_REG_OFFSET 12'h000
`define POWER_FAIL_CONFIG_REG_OFFSET 12'h004
`define WAKE_CONTROL_OFFSET 12'h008
`define WAKE_STATUS_OFFSET 12'h00c

`define TIMER_STANDBY_SELECT_BIT 6
`define CLOCK_CONTROL_RESET 8'h00
`define POWER_FAIL_DISABLE_BIT 0
`define POWER_FAIL_RESET_SELECT_BIT 1
`define POWER_FAIL_CONFIG_RESET 8'h00
`define HALT_BIT 0
`define GLOBAL_IRQ_ENABLE_BIT 1

`define MCLK_HZ 100000000
`define RESET_LOW_PERIODS 8
`define STARTUP_DELAY_MS 64
`define STARTUP_EXTRA_PERIODS 7
`define PFAIL_GLITCH_NS 50
`define PRESCALE_RATIO 2048

`endif

// file: shared/standby_wake_pkg.sv
// Types shared by the standby, wake and reset sequencer.
package standby_wake_pkg;

    typedef enum logic [4:0] {
        ST_RESET = 5'b00001,
        ST_START = 5'b00010,
        ST_RUN = 5'b00100,
        ST_STANDBY = 5'b01000,
        ST_WAKE = 5'b10000
    } seq_state_t;

    typedef enum logic [1:0] {
        WAKE_NONE = 2'h0,
        WAKE_RESUME = 2'h1,
        WAKE_VECTOR = 2'h2
    } wake_action_t;

    typedef struct packed {
        logic first_wake_timer;
        logic second_wake_timer;
        logic ext_irq;
    } wake_src_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage

// file: testbench/board_side_model.sv
// Reset pin and supply monitor as seen from the board.
`timescale 1ns/1ps
module board_side_model (
    input wire logic clk,
    output logic reset_pin_b,
    output logic supply_low
);
    // The pin has a pull-up, so a released pin reads high.
    initial begin
        reset_pin_b = 1'b1;
        supply_low = 1'b0;
    end
    task automatic pin_low(input int n);
        reset_pin_b <= 1'b0;
        repeat (n) @(posedge clk);
        reset_pin_b <= 1'b1;
    endtask
    task automatic supply_dip(input int n);
        supply_low <= 1'b1;
        repeat (n) @(posedge clk);
        supply_low <= 1'b0;
    endtask
endmodule

// file: testbench/standby_wake_sva.sv
// Port checker for the standby, wake and reset sequencer.
`timescale 1ns/1ps
module standby_wake_sva
    import standby_wake_pkg::*;
#(
    parameter int STARTUP_CYCLES = 20
) (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic RESET_PIN_B,
    input wire logic SUPPLY_LOW,
    input wire logic POWER_FAIL_LEVEL_SELECT,
    input wire logic HALT_EXEC,
    input wire logic FIRST_WAKE_TIMER_OVF,
    input wire logic SECOND_WAKE_TIMER_OVF,
    input wire logic EXT_IRQ,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic CORE_RESET_B,
    input wire logic CORE_RUN,
    input wire logic CORE_RESUME,
    input wire logic CORE_VECTOR,
    input wire logic PRESCALE_TICK,
    input wire logic WAKE_TIMER_RUN,
    input wire logic STANDBY_ACTIVE,
    input wire logic POWER_FAIL_LEVEL
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    ////////////////////////////////////////////////////////////////////////
    // Shadow copies of the bits that steer the sequencer, plus counters.
    logic cc6, pf_dis, pf_sel, irq_en, seen;
    logic [11:0] gap;
    int low_cnt;
    wire wr = PSEL && PENABLE && PWRITE && PREADY;
    wire any_wake = FIRST_WAKE_TIMER_OVF || SECOND_WAKE_TIMER_OVF || EXT_IRQ;
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            {cc6, pf_dis, pf_sel, irq_en, seen} <= '0;
            gap <= '0;
            low_cnt <= 0;
        end else begin
            low_cnt <= CORE_RESET_B ? 0 : low_cnt + 1;
            gap <= PRESCALE_TICK ? 12'h000 : gap + 12'h001;
            seen <= CORE_RESET_B && (seen || PRESCALE_TICK);
            if (!CORE_RESET_B) begin
                {cc6, pf_dis, pf_sel, irq_en} <= '0;
            end else if (wr && PADDR == 12'h000) begin
                cc6 <= PWDATA[6];
            end else if (wr && PADDR == 12'h004) begin
                {pf_sel, pf_dis} <= PWDATA[1:0];
            end else if (wr && PADDR == 12'h008) begin
                irq_en <= PWDATA[1];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_halt; HALT_EXEC && CORE_RUN && cc6; endsequence
    sequence s_pin_low; !RESET_PIN_B [*8]; endsequence
    sequence s_supply_low; (pf_sel && !pf_dis && SUPPLY_LOW) [*8]; endsequence
    property p_exit;
        $fell(STANDBY_ACTIVE) |-> !CORE_RESET_B || $past(any_wake, 2) || $past(any_wake, 3)
            || $past(any_wake, 4) || $past(any_wake, 5);
    endproperty
    property p_vector; CORE_VECTOR |-> irq_en && !CORE_RESUME && CORE_RUN; endproperty
    property p_resume; CORE_RESUME |-> !irq_en && CORE_RUN; endproperty
    property p_wake_fast; STANDBY_ACTIVE && any_wake |-> ##[1:6] (CORE_RESUME || CORE_VECTOR); endproperty
    property p_halt; s_halt |=> STANDBY_ACTIVE && !CORE_RUN && WAKE_TIMER_RUN; endproperty
    property p_tick; PRESCALE_TICK && seen |-> gap == 12'h7ff; endproperty
    property p_pin; s_pin_low |-> ##[0:6] !CORE_RESET_B; endproperty
    property p_pfail; s_supply_low |-> ##[0:6] !CORE_RESET_B; endproperty
    property p_startup; $rose(CORE_RESET_B) |-> CORE_RUN && low_cnt >= STARTUP_CYCLES - 1; endproperty
    property p_level; $stable(POWER_FAIL_LEVEL_SELECT) [*6] |-> POWER_FAIL_LEVEL == POWER_FAIL_LEVEL_SELECT; endproperty
    a_exit: assert property (p_exit) else $error("standby left without a wake cause");
    a_vector: assert property (p_vector) else $error("vector with interrupts disabled");
    a_resume: assert property (p_resume) else $error("resume with interrupts enabled");
    a_wake_fast: assert property (p_wake_fast) else $error("wake response too slow");
    a_halt: assert property (p_halt) else $error("halt did not enter standby");
    a_tick: assert property (p_tick) else $error("prescaler tick spacing wrong");
    a_pin: assert property (p_pin) else $error("long pin low gave no reset");
    a_pfail: assert property (p_pfail) else $error("power fail gave no reset");
    a_startup: assert property (p_startup) else $error("startup delay too short");
    a_level: assert property (p_level) else $error("threshold select not passed on");
endmodule
bind standby_wake_reset_control standby_wake_sva #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk (.*);

// file: testbench/tb_standby_wake_reset_control.sv
// Self-checking bench for the standby, wake and reset sequencer.
`timescale 1ns/1ps
module tb_standby_wake_reset_control
    import standby_wake_pkg::*;
;
    logic mclk, rst_b, halt, lvl_sel, pready, pslverr, core_rst_b, run, resume, vector, stby, pf_level, e, vec, res;
    logic trun;
    logic [31:0] prdata, q, seed;
    logic [2:0] src_o, last_src;
    wake_src_t wake;
    apb_req_t req;
    wire pin_b, sup;
    int errors, checked, n, mdl[3];
    int len[4] = '{12, 12, 3, 12};
    logic [1:0] cfg[4] = '{2'h3, 2'h0, 2'h2, 2'h2};
    board_side_model bsm (.clk(mclk), .reset_pin_b(pin_b), .supply_low(sup));
    standby_wake_reset_control #(.STARTUP_CYCLES(20), .CNT_WIDTH(24)) uut (
        .MCLK(mclk), .RST_B(rst_b), .RESET_PIN_B(pin_b), .SUPPLY_LOW(sup), .POWER_FAIL_LEVEL_SELECT(lvl_sel),
        .HALT_EXEC(halt), .FIRST_WAKE_TIMER_OVF(wake.first_wake_timer),
        .SECOND_WAKE_TIMER_OVF(wake.second_wake_timer), .EXT_IRQ(wake.ext_irq),
        .PSEL(req.psel), .PENABLE(req.penable), .PWRITE(req.pwrite), .PADDR(req.paddr), .PWDATA(req.pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CORE_RESET_B(core_rst_b), .CORE_RUN(run),
        .CORE_RESUME(resume), .CORE_VECTOR(vector), .CORE_WAKE_SRC(src_o), .PRESCALE_TICK(),
        .WAKE_TIMER_RUN(trun), .STANDBY_ACTIVE(stby), .POWER_FAIL_LEVEL(pf_level)
    );
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic stop_test();
        if (errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge mclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge mclk);
        req.penable <= 1'b1;
        // Ready, data and error are taken at the rising edge that samples ready high, then released.
        do begin
            @(posedge mclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        q = prdata;
        e = pslverr;
        req <= '0;
        if (t >= 50) errors++;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        check("wr_err", e, a > 12'h00c);
        if (a <= 12'h008) mdl[a[3:2]] = d & (a == 12'h008 ? 32'h2 : 32'hff);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, '0);
        check("prdata", q, a == 12'h00c ? {21'h0, last_src, 8'h04} : a > 12'h00c ? 32'h0 : mdl[a[3:2]]);
        check("rd_err", e, a > 12'h00c);
    endtask
    task automatic rd_all();
        for (int i = 0; i < 5; i++) rd(12'(i * 4));
    endtask
    task automatic wait_run();
        n = 0;
        {vec, res} = '0;
        do begin
            @(negedge mclk);
            n++;
            vec |= vector;
            res |= resume;
        end while (run !== 1'b1 && n < 300);
        if (run !== 1'b1) errors++;
    endtask
    task automatic halt_op();
        @(posedge mclk);
        halt <= 1'b1;
        @(posedge mclk);
        halt <= 1'b0;
        repeat (2) @(negedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_b, halt, lvl_sel, wake, req, errors, checked, last_src} = '0;
        mdl = '{default: 0};
        seed = 32'hfa59;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        wait_run();
        check("startup", n >= 20 && n <= 23, 1);
        rd_all();
        wr(12'h010, xs());
        @(posedge mclk);
        lvl_sel <= 1'b1;
        repeat (6) @(negedge mclk);
        check("level", pf_level, 1);
        halt_op();
        check("standby_off", stby, 0);
        for (int k = 0; k < 6; k++) begin
            wr(12'h008, 32'(k / 3) << 1);
            wr(12'h000, 32'h40);
            halt_op();
            check("standby", {stby, run, trun}, 3'b101);
            repeat (k == 0 ? 4200 : 1 + xs() % 8) @(posedge mclk);
            wake <= wake_src_t'(3'b100 >> (k % 3));
            @(posedge mclk);
            wake <= '0;
            wait_run();
            last_src = 3'b100 >> (k % 3);
            check("vector", vec, k / 3);
            check("resume", res, k < 3);
            check("src", src_o, last_src);
            check("latency", n <= 6, 1);
            rd_all();
        end
        for (int k = 0; k < 4; k++) begin
            wr(12'h004, {30'h0, cfg[k]});
            @(posedge mclk);
            bsm.supply_dip(len[k]);
            repeat (8) @(negedge mclk);
            check("pfail", core_rst_b, k < 3);
        end
        mdl = '{default: 0};
        last_src = '0;
        wait_run();
        rd_all();
        wr(12'h000, 32'h40);
        halt_op();
        @(posedge mclk);
        bsm.pin_low(12);
        repeat (4) @(negedge mclk);
        check("pin", {core_rst_b, stby}, 2'b00);
        mdl = '{default: 0};
        wait_run();
        rd_all();
        stop_test();
    end
    initial begin
        repeat (30000) @(posedge mclk);
        errors++;
        stop_test();
    end
endmodule
